// File: core/acs_pkg.sv
// Constants and types for the converter sequencer
package acs_pkg;
  localparam logic [7:0] ACS_OFF_CTL2   = 8'h62;
  localparam logic [7:0] ACS_OFF_CTL3   = 8'h63;
  localparam logic [7:0] ACS_OFF_CTL5   = 8'h65;
  localparam logic [7:0] ACS_OFF_STAT0  = 8'h66;
  localparam logic [7:0] ACS_OFF_STAT1  = 8'h67;
  localparam logic [7:0] ACS_OFF_TSTH   = 8'h68;
  localparam logic [7:0] ACS_OFF_TSTL   = 8'h69;
  localparam logic [7:0] ACS_OFF_RES0   = 8'h70;
  localparam logic [7:0] ACS_OFF_RES7   = 8'h7f;
  localparam logic [7:0] ACS_RESET_VAL  = 8'h00;
  localparam int ACS_B_EIGHT_CONVERSION_SELECT   = 6;
  localparam int ACS_B_SCAN   = 5;
  localparam int ACS_B_GROUP_SWEEP_ENABLE   = 4;
  localparam int ACS_B_PWR    = 7;
  localparam int ACS_B_FAST_FLAG_CLEAR   = 6;
  localparam int ACS_B_IE     = 1;
  localparam int ACS_B_RST    = 5;
  localparam int ACS_B_TOUT   = 4;
  localparam logic [7:0] ACS_CTL5_MASK = 8'h7f;
  localparam logic [7:0] ACS_CTL2_MASK = 8'he2;
  localparam logic [7:0] ACS_CTL3_MASK = 8'h03;
  localparam logic [2:0] ACS_LEN4_LAST = 3'h3;
  localparam logic [2:0] ACS_LEN8_LAST = 3'h7;
  typedef enum logic [1:0] {ACS_IDLE, ACS_START, ACS_CONV} acs_state_t;
endpackage : acs_pkg

// File: core/acs_sequencer.sv
// Conversion sequencer, status flags and test access for the converter
//
// Behaviour
// - Control writes always accepted; each starts sequence while powered up
// - Write mid-sequence aborts, clears all flags
// - Length select: four or eight conversions
// - Repeat bit: one sequence or continuous
// - Single channel uses all four select bits
// - Group sweep steps channels, ignores low bits
// - Channel codes: inputs, reserved, references, test
// - Group sweep results follow low code bits
// - Sequence flag sets after first sequence
// - Sequence flag clears on start or, with fast clear set, on slot0 read
// - Readable counter shows next result slot
// - Per-slot done flag set until read
// - Fast clear ignores status read; else needed
// - Status writable only in special mode
// - Test registers special mode only, else zero
// - Test field reads/writes approximation register
// - Soft reset restores all but power-up
// - Factory test select and mux output
// - Unused bits read zero; resets zero
// - Fast clear bit: access clears set flag
// - Power/freeze writes or power-down abort sequence
// - Results left justified, read-only in every mode
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        special_mode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             conv_start,
  output logic      [3:0]  conv_channel,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_value,
  output logic             converter_irq,
  output logic      [3:0]  factory_test_select,
  output logic             test_mux_output
);
  acs_state_t  state_r;
  logic [7:0]  ctl5_r;
  logic [7:0]  ctl2_r;
  logic [7:0]  ctl3_r;
  logic [2:0]  conversion_counter_r;
  logic        sequence_complete_flag_r;
  logic        first_seq_r;
  logic [7:0]  conversion_done_flags_r;
  logic [7:0]  stat_armed_r;
  logic [9:0]  approximation_value_r;
  logic        tst_out_r;
  logic [3:0]  tst_sel_r;
  logic [15:0] result_r [8];
  logic        soft_rst;

  // Byte offset: register index is paddr[11:2]
  function automatic logic hit(input logic [11:0] a, input logic [7:0] off);
    return a[11:2] == {2'b00, off};
  endfunction

  // Result window covers both bytes of all eight slots
  function automatic logic in_results(input logic [11:0] a);
    return a[11:2] >= {2'b00, ACS_OFF_RES0} && a[11:2] <= {2'b00, ACS_OFF_RES7};
  endfunction

  // High byte at the even offset, low byte at the odd one
  function automatic logic [7:0] slot_byte(input logic [15:0] v, input logic low);
    return low ? v[7:0] : v[15:8];
  endfunction

  // Sweep code: counter replaces the in-group bits, upper bits pick the group
  function automatic logic [3:0] sweep_channel(input logic [7:0] ctl, input logic [2:0] cnt);
    if (ctl[ACS_B_EIGHT_CONVERSION_SELECT])
      return {ctl[3], cnt};
    return {ctl[3:2], cnt[1:0]};
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic       wr_ctl5;
  logic       wr_ctl2;
  logic       wr_ctl3;
  logic       wr_tsth;
  logic       wr_tstl;
  logic       wr_st0;
  logic       wr_st1;
  logic       rd_st;
  logic       res_acc;
  logic       res_hit;
  logic [2:0] res_idx;
  logic [2:0] last_idx;
  logic       aborting;
  assign acc     = psel && penable && clk_en;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign wr_ctl5 = wr && hit(paddr, ACS_OFF_CTL5);
  assign wr_ctl2 = wr && hit(paddr, ACS_OFF_CTL2);
  assign wr_ctl3 = wr && hit(paddr, ACS_OFF_CTL3);
  // Test and status writes need special mode
  assign wr_tsth = wr && special_mode && hit(paddr, ACS_OFF_TSTH);
  assign wr_tstl = wr && special_mode && hit(paddr, ACS_OFF_TSTL);
  assign wr_st0  = wr && special_mode && hit(paddr, ACS_OFF_STAT0);
  assign wr_st1  = wr && special_mode && hit(paddr, ACS_OFF_STAT1);
  assign rd_st   = rd && (hit(paddr, ACS_OFF_STAT0) || hit(paddr, ACS_OFF_STAT1));
  // High and low bytes of a slot share one slot index
  assign res_hit = in_results(paddr);
  assign res_acc = acc && res_hit;
  assign res_idx = paddr[5:3];

  // Soft reset is a one-cycle strobe; the bit itself never stores
  assign soft_rst = wr_tstl && pwdata[ACS_B_RST];
  assign last_idx = ctl5_r[ACS_B_EIGHT_CONVERSION_SELECT] ? ACS_LEN8_LAST : ACS_LEN4_LAST;
  assign aborting = wr_ctl2 || wr_ctl3;

  // Zero wait states: every access completes in one access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Conversion control; the write itself starts the sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ctl5_r <= ACS_RESET_VAL;
    else if (clk_en) begin
      if (soft_rst)
        ctl5_r <= ACS_RESET_VAL;
      else if (wr_ctl5)
        ctl5_r <= pwdata[7:0] & ACS_CTL5_MASK;
    end
  end

  // Freeze control: stored only, the write aborts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ctl3_r <= ACS_RESET_VAL;
    else if (clk_en) begin
      if (soft_rst)
        ctl3_r <= ACS_RESET_VAL;
      else if (wr_ctl3)
        ctl3_r <= pwdata[7:0] & ACS_CTL3_MASK;
    end
  end

  // Power-up bit survives soft reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ctl2_r <= ACS_RESET_VAL;
    else if (clk_en) begin
      if (soft_rst)
        ctl2_r <= ACS_RESET_VAL | {ctl2_r[ACS_B_PWR], 7'h00};
      else if (wr_ctl2)
        ctl2_r <= pwdata[7:0] & ACS_CTL2_MASK;
    end
  end

  // Sequencer state; any abort or loss of power parks it
  logic stop_req;
  logic seq_end;
  assign stop_req = soft_rst || aborting || !ctl2_r[ACS_B_PWR];
  assign seq_end  = (state_r == ACS_CONV) && conv_done && conversion_counter_r == last_idx;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      state_r <= ACS_IDLE;
    else if (clk_en) begin
      if (stop_req)
        state_r <= ACS_IDLE;
      else if (wr_ctl5)
        state_r <= ACS_START;
      else begin
        case (state_r)
          ACS_IDLE:  state_r <= ACS_IDLE;
          ACS_START: state_r <= ACS_CONV;
          ACS_CONV: begin
            if (seq_end)
              state_r <= ctl5_r[ACS_B_SCAN] ? ACS_START : ACS_IDLE;
            else if (conv_done)
              state_r <= ACS_START;
          end
          default:   state_r <= ACS_IDLE;
        endcase
      end
    end
  end

  // Conversion counter: next slot to be written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      conversion_counter_r <= 3'h0;
    else if (clk_en) begin
      if (stop_req || wr_ctl5 || seq_end)
        conversion_counter_r <= 3'h0;
      else if (state_r == ACS_CONV && conv_done)
        conversion_counter_r <= conversion_counter_r + 3'h1;
    end
  end

  // Only the first sequence after a start may set the sequence flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      first_seq_r <= 1'b0;
    else if (clk_en) begin
      if (soft_rst)
        first_seq_r <= 1'b0;
      else if (wr_ctl5 && !stop_req)
        first_seq_r <= 1'b1;
      else if (seq_end && !stop_req)
        first_seq_r <= 1'b0;
    end
  end

  // One request per conversion; the core times the conversion itself
  assign conv_start = (state_r == ACS_START);
  always_comb begin
    if (ctl5_r[ACS_B_GROUP_SWEEP_ENABLE])
      conv_channel = sweep_channel(ctl5_r, conversion_counter_r);
    else
      conv_channel = ctl5_r[3:0];
  end

  // A result that lands in an aborting cycle is dropped
  logic done_ev;
  assign done_ev = (state_r == ACS_CONV) && conv_done && !stop_req && !wr_ctl5;

  // Results: slot index equals counter, which equals low code bits in sweep
  // No reset: slot contents are undefined until first written
  for (genvar s = 0; s < 8; s++) begin : g_result
    always_ff @(posedge clk) begin
      if (clk_en && done_ev && conversion_counter_r == 3'(s))
        result_r[s] <= {conv_value, 6'h00};
    end
  end

  // Sequence complete flag: set beats the software clears
  logic scf_set;
  logic scf_clr;
  assign scf_set = done_ev && conversion_counter_r == last_idx && first_seq_r;
  assign scf_clr = res_acc && res_idx == 3'h0 && !pwrite && ctl2_r[ACS_B_FAST_FLAG_CLEAR];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      sequence_complete_flag_r <= 1'b0;
    else if (clk_en) begin
      if (soft_rst || wr_ctl5)
        sequence_complete_flag_r <= 1'b0;
      else if (scf_set)
        sequence_complete_flag_r <= 1'b1;
      else if (wr_st0)
        sequence_complete_flag_r <= pwdata[7];
      else if (scf_clr)
        sequence_complete_flag_r <= 1'b0;
    end
  end

  // Completion flags; set beats clear
  for (genvar f = 0; f < 8; f++) begin : g_done_flag
    logic set_ev;
    logic clr_ev;
    assign set_ev = done_ev && conversion_counter_r == 3'(f);
    // Without fast clear only a read armed by a status read clears
    assign clr_ev = res_acc && res_idx == 3'(f) &&
                    (ctl2_r[ACS_B_FAST_FLAG_CLEAR] || !pwrite && stat_armed_r[f]);
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
        conversion_done_flags_r[f] <= 1'b0;
      else if (clk_en) begin
        if (soft_rst || wr_ctl5)
          conversion_done_flags_r[f] <= 1'b0;
        else if (set_ev)
          conversion_done_flags_r[f] <= 1'b1;
        else if (wr_st1)
          conversion_done_flags_r[f] <= pwdata[f];
        else if (clr_ev)
          conversion_done_flags_r[f] <= 1'b0;
      end
    end
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
        stat_armed_r[f] <= 1'b0;
      else if (clk_en) begin
        if (soft_rst || wr_ctl5 || set_ev || clr_ev)
          stat_armed_r[f] <= 1'b0;
        else if (rd_st)
          stat_armed_r[f] <= conversion_done_flags_r[f];
      end
    end
  end

  // Approximation register: a test write wins over a conversion result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      approximation_value_r <= 10'h000;
    else if (clk_en) begin
      if (soft_rst)
        approximation_value_r <= 10'h000;
      else if (wr_tsth)
        approximation_value_r[9:2] <= pwdata[7:0];
      else if (wr_tstl)
        approximation_value_r[1:0] <= pwdata[7:6];
      else if (done_ev)
        approximation_value_r <= conv_value;
    end
  end

  // Factory test selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tst_out_r <= 1'b0;
      tst_sel_r <= 4'h0;
    end else if (clk_en) begin
      if (soft_rst) begin
        tst_out_r <= 1'b0;
        tst_sel_r <= 4'h0;
      end else if (wr_tstl) begin
        tst_out_r <= pwdata[ACS_B_TOUT];
        tst_sel_r <= pwdata[3:0];
      end
    end
  end

  assign factory_test_select = tst_sel_r;
  assign test_mux_output     = tst_out_r && tst_sel_r != 4'h0;
  // Level request; software clears it through the sequence flag
  assign converter_irq = sequence_complete_flag_r && ctl2_r[ACS_B_IE];

  // Read data register
  logic [7:0]  rd_byte;
  logic [15:0] slot;
  always_comb begin
    slot    = result_r[res_idx];
    rd_byte = 8'h00;
    if (hit(paddr, ACS_OFF_CTL5))
      rd_byte = ctl5_r;
    else if (hit(paddr, ACS_OFF_CTL2))
      rd_byte = ctl2_r | {7'h00, sequence_complete_flag_r};
    else if (hit(paddr, ACS_OFF_CTL3))
      rd_byte = ctl3_r;
    else if (hit(paddr, ACS_OFF_STAT0))
      rd_byte = {sequence_complete_flag_r, 4'h0, conversion_counter_r};
    else if (hit(paddr, ACS_OFF_STAT1))
      rd_byte = conversion_done_flags_r;
    else if (hit(paddr, ACS_OFF_TSTH))
      rd_byte = special_mode ? approximation_value_r[9:2] : 8'h00;
    else if (hit(paddr, ACS_OFF_TSTL))
      rd_byte = special_mode ? {approximation_value_r[1:0], 1'b0, tst_out_r, tst_sel_r} : 8'h00;
    else if (res_hit)
      rd_byte = slot_byte(slot, paddr[2]);
  end

  // Loaded in the setup cycle so data stands through the access phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite)
      prdata <= {24'h000000, rd_byte};
  end
endmodule : acs_sequencer

// File: dv/acs_sequencer_asserts.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module acs_sequencer_asserts
  import acs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic        special_mode,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_start,
  input wire logic [3:0]  conv_channel,
  input wire logic        converter_irq,
  input wire logic [3:0]  factory_test_select,
  input wire logic        test_mux_output
);
  logic wr5, rds, pwr_r;
  assign wr5 = psel && penable && pwrite && clk_en && paddr[9:2] == ACS_OFF_CTL5;
  assign rds = psel && !penable && !pwrite && clk_en;
  // Shadow of the power bit: starts only run while powered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      pwr_r <= 1'b0;
    else if (psel && penable && pwrite && clk_en && paddr[9:2] == ACS_OFF_CTL2)
      pwr_r <= pwdata[ACS_B_PWR];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_ready_no_err: assert property (psel |-> pready && !pslverr) else $error("bus answer wrong");
  chk_test_read_zero: assert property (rds && !special_mode && paddr[9:3] == ACS_OFF_TSTH[7:1]
    |=> prdata == 32'h0) else $error("test reg not zero");
  chk_stat_unused: assert property (rds && paddr[9:2] == ACS_OFF_STAT0 |=> prdata[6:3] == 4'h0)
    else $error("status unused bits set");
  chk_write_starts: assert property (wr5 && pwr_r |=> conv_start) else $error("no start");
  chk_start_single: assert property (conv_start && clk_en && !wr5 |=> !conv_start)
    else $error("start held");
  chk_irq_cleared: assert property (wr5 |=> !converter_irq) else $error("irq kept");
  chk_single_chan: assert property (wr5 && pwr_r && !pwdata[ACS_B_GROUP_SWEEP_ENABLE]
    |=> conv_channel == $past(pwdata[3:0])) else $error("single channel wrong");
  chk_group_base: assert property (wr5 && pwr_r && pwdata[ACS_B_GROUP_SWEEP_ENABLE] |=> conv_channel ==
    ($past(pwdata[6]) ? {$past(pwdata[3]), 3'h0} : {$past(pwdata[3:2]), 2'h0})) else $error("group base wrong");
  chk_mux_idle: assert property (factory_test_select == 4'h0 |-> !test_mux_output)
    else $error("mux out without select");
endmodule // acs_sequencer_asserts

bind acs_sequencer acs_sequencer_asserts i_acs_sequencer_asserts (.clk, .rst_b, .clk_en, .special_mode,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_channel,
  .converter_irq, .factory_test_select, .test_mux_output);

// File: dv/acs_core_model.sv
// Behavioural analog core answering conversion requests
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] dly,
  input  wire logic       conv_start,
  input  wire logic [3:0] conv_channel,
  output logic            conv_done,
  output logic      [9:0] conv_value
);
  logic [7:0] cnt_r;
  logic [9:0] val_r;
  // Value encodes the channel so slot steering shows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      conv_done <= 1'b0;
      val_r <= 10'h000;
    end else begin
      conv_done <= cnt_r == 8'h01 && !conv_start;
      if (conv_start) begin
        cnt_r <= dly;
        val_r <= {conv_channel, 6'h15};
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  // Off the pulse the value is scrambled, never the last result
  assign conv_value = conv_done ? val_r : ~val_r;
endmodule // acs_core_model

// File: dv/tb.sv
// Register-level testbench for the converter sequencer
`timescale 1ns/1ps
module tb
  import acs_pkg::*;
;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, special_mode = 0, clk_en = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, conv_start, conv_done, converter_irq, test_mux_output;
  logic [3:0]  conv_channel, factory_test_select;
  logic [9:0]  conv_value;
  logic [7:0]  dly = 2, r, offs [5] = '{ACS_OFF_CTL5, ACS_OFF_STAT0, ACS_OFF_STAT1, ACS_OFF_TSTH, ACS_OFF_TSTL};
  int          err_count = 0, n_checks = 0, n_start = 0, s0;
  always #20 clk = ~clk;
  always @(posedge clk) if (conv_start === 1'b1) n_start++;
  acs_sequencer i_acs_sequencer (.clk, .rst_b, .clk_en, .special_mode, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_channel, .conv_done, .conv_value,
    .converter_irq, .factory_test_select, .test_mux_output);
  acs_core_model i_acs_core_model (.clk, .rst_b, .dly, .conv_start, .conv_channel, .conv_done, .conv_value);
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, e);
    bus(0, a, 8'h00);
    chk($sformatf("reg %h", a), e, r);
  endtask
  // Bounded so a silent core cannot hang the run
  task automatic wdn(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin @(posedge clk); k++; end while (conv_done !== 1'b1 && k < 400);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    foreach (offs[i]) rdc(offs[i], 8'h00);
    bus(1, ACS_OFF_CTL2, 8'h80);
    dly <= 40;
    bus(1, ACS_OFF_CTL5, 8'h05);
    wdn(2);
    rdc(ACS_OFF_STAT0, 8'h02);
    rdc(ACS_OFF_STAT1, 8'h03);
    bus(1, ACS_OFF_CTL5, 8'h05);
    rdc(ACS_OFF_STAT1, 8'h00);
    dly <= 2;
    wdn(4);
    rdc(8'h72, 8'h55);
    rdc(8'h73, 8'h40);
    rdc(ACS_OFF_STAT1, 8'h0f);
    rdc(8'h72, 8'h55);
    rdc(ACS_OFF_STAT1, 8'h0d);
    bus(0, ACS_OFF_STAT0, 8'h00);
    chk("seq flag", 8'h80, r & 8'h80);
    bus(1, ACS_OFF_CTL2, 8'hc2);
    s0 = n_start;
    bus(1, ACS_OFF_CTL5, 8'h5c);
    wdn(8);
    chk("irq", 8'h01, {7'h0, converter_irq});
    rdc(ACS_OFF_STAT1, 8'hff);
    rdc(8'h7a, 8'hd5);
    rdc(ACS_OFF_STAT1, 8'hdf);
    rdc(8'h70, 8'h85);
    chk("starts", 8'(s0 + 8), n_start[7:0]);
    bus(0, ACS_OFF_STAT0, 8'h00);
    chk("seq flag", 8'h00, r & 8'h80);
    chk("irq", 8'h00, {7'h0, converter_irq});
    dly <= 40;
    bus(1, ACS_OFF_CTL5, 8'h20);
    wdn(6);
    rdc(ACS_OFF_STAT0, 8'h82);
    rdc(ACS_OFF_CTL5, 8'h20);
    bus(1, ACS_OFF_CTL2, 8'h80);
    s0 = n_start;
    repeat (100) @(posedge clk);
    chk("starts", s0[7:0], n_start[7:0]);
    special_mode <= 1;
    bus(1, ACS_OFF_TSTH, 8'ha5);
    bus(1, ACS_OFF_TSTL, 8'h53);
    rdc(ACS_OFF_TSTH, 8'ha5);
    chk("test sel", 8'h13, {3'h0, test_mux_output, factory_test_select});
    bus(1, ACS_OFF_STAT1, 8'h3c);
    rdc(ACS_OFF_STAT1, 8'h3c);
    bus(1, ACS_OFF_TSTL, 8'h20);
    rdc(ACS_OFF_CTL2, 8'h80);
    rdc(ACS_OFF_STAT1, 8'h00);
    special_mode <= 0;
    bus(1, ACS_OFF_STAT1, 8'hff);
    rdc(ACS_OFF_STAT1, 8'h00);
    bus(1, ACS_OFF_TSTH, 8'hff);
    rdc(ACS_OFF_TSTH, 8'h00);
    rdc(8'h6a, 8'h00);
    final_report();
  end
endmodule // tb
